// *** src/awd_pkg.sv ***
// Purpose: shared constants and types for the ata write/diagnostic/password command block
// Assumes: one 50 MHz clock, synchronous active-low reset
// Notes: task-file register indexes are 3-bit register selects on the link
package awd_pkg;
  // ----------------------------------------------------------------
  // task-file register selects
  // ----------------------------------------------------------------
  localparam logic [2:0] TF_ERR_FEAT = 3'h1;
  localparam logic [2:0] TF_COUNT = 3'h2;
  localparam logic [2:0] TF_ADDR0 = 3'h3;
  localparam logic [2:0] TF_ADDR1 = 3'h4;
  localparam logic [2:0] TF_ADDR2 = 3'h5;
  localparam logic [2:0] TF_DEVHEAD = 3'h6;
  localparam logic [2:0] TF_STAT_CMD = 3'h7;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_PIO = 8'h30;
  localparam logic [7:0] CMD_WRITE_DMA = 8'hca;
  localparam logic [7:0] CMD_DIAG = 8'h90;
  localparam logic [7:0] CMD_PW_SET = 8'hf1;
  // ----------------------------------------------------------------
  // status, error, drive/head and password control word bit positions
  // ----------------------------------------------------------------
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_DREQ = 3;
  localparam int ST_FAIL = 0;
  localparam int ER_CRC = 7;
  localparam int ER_NOADDR = 4;
  localparam int ER_ABORT = 2;
  localparam int DH_LBA_MODE = 6;
  localparam int DH_DRIVE_SEL = 4;
  localparam int PW_ID_BIT = 0;
  localparam int PW_LEVEL_BIT = 8;
  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET = 8'h40;
  localparam logic [7:0] TF_RESET = 8'h00;
  localparam logic [7:0] DIAG_PASS = 8'h01;
  localparam logic [7:0] WORD_LAST = 8'hff;
  localparam logic [8:0] SECTORS_ZERO_COUNT = 9'h100;
  localparam logic [7:0] PW_WORD_FIRST = 8'h01;
  localparam logic [7:0] PW_WORD_LAST = 8'h10;
  localparam logic [7:0] PW_REV_WORD = 8'h11;
  localparam logic [15:0] MASTER_REV_RESET = 16'hfffe;
  localparam logic [8:0] HOST_PW_WORDS = 9'h100;
  // ----------------------------------------------------------------
  // device command sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {AWD_IDLE, AWD_PIO, AWD_DMA, AWD_PW} awd_state_e;
endpackage : awd_pkg

// *** src/awd_link_if.sv ***
// Purpose: task-file and data-word link between host controller and device
// Assumes: both ends on clk_in; every signal driven by a flip-flop
// Notes: register read data stand the cycle after the read strobe
`timescale 1ns/10ps
interface awd_link_if;
  logic tf_wr;
  logic tf_rd;
  logic [2:0] tf_addr;
  logic [7:0] tf_wdata;
  logic [7:0] tf_rdata;
  logic dat_valid;
  logic [15:0] dat_word;
  logic dat_crc_err;
  logic dat_ready;
  logic intrq;
  // ----------------------------------------------------------------
  // party views
  // ----------------------------------------------------------------
  modport dev (input tf_wr, tf_rd, tf_addr, tf_wdata, dat_valid, dat_word, dat_crc_err,
               output tf_rdata, dat_ready, intrq);
  modport host (output tf_wr, tf_rd, tf_addr, tf_wdata, dat_valid, dat_word, dat_crc_err,
                input tf_rdata, dat_ready, intrq);
endinterface : awd_link_if

// *** src/awd_pw_capture.sv ***
// Purpose: captures the 512-byte password block and commits the stored passwords
// Assumes: word_idx counts 0..255 within the block, commit only after the last word
// Notes: staging is overwritten by the next block; only commit updates stored state
`timescale 1ns/10ps
module awd_pw_capture
  import awd_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // word stream
  input wire logic word_valid_in,
  input wire logic [7:0] word_idx_in,
  input wire logic [15:0] word_in,
  input wire logic commit_in,
  // stored state
  output logic [255:0] user_pw_out,
  output logic [255:0] master_pw_out,
  output logic level_max_out,
  output logic lock_armed_out,
  output logic [15:0] master_rev_out
);
  logic [15:0] stage_r [16];
  logic [15:0] ctl_r;
  logic [15:0] rev_r;
  logic [255:0] stage_flat;

  // staging of control word, password words and revision word
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ctl_r <= 16'h0000;
      rev_r <= 16'h0000;
      for (int i = 0; i < 16; i++) stage_r[i] <= 16'h0000;
    end else if (word_valid_in) begin
      if (word_idx_in == 8'h00) ctl_r <= word_in;
      if (word_idx_in == PW_REV_WORD) rev_r <= word_in;
      if (word_idx_in >= PW_WORD_FIRST && word_idx_in <= PW_WORD_LAST)
        stage_r[word_idx_in[3:0] - 4'h1] <= word_in;
    end
  end

  // word 1 sits in the low bits of the stored password
  always_comb begin
    stage_flat = '0;
    for (int i = 0; i < 16; i++) stage_flat[i*16 +: 16] = stage_r[i];
  end

  // commit: user password arms the lock, master password keeps lock and level
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      user_pw_out <= '0;
      master_pw_out <= '0;
      level_max_out <= 1'b0;
      lock_armed_out <= 1'b0;
      master_rev_out <= MASTER_REV_RESET;
    end else if (commit_in) begin
      if (!ctl_r[PW_ID_BIT]) begin
        user_pw_out <= stage_flat;
        lock_armed_out <= 1'b1;
        level_max_out <= ctl_r[PW_LEVEL_BIT];
      end else begin
        master_pw_out <= stage_flat;
        master_rev_out <= rev_r;
      end
    end
  end
endmodule : awd_pw_capture

// *** src/awd_device.sv ***
// Purpose: device end; decodes task-file commands, moves sector data, reports completion
// Assumes: host follows the link contract; media back end flags errors per sector
// Notes: task-file writes are ignored while busy; one interrupt per finished pio data block and at each completion
//
// Summary of operation
// - command 30h is a pio sector write
// - address from three bytes plus head nibble
// - count of zero means 256 sectors
// - host sets lba mode bit 6
// - drive select bit reported back unchanged
// - success: ready set, all else clear; here the fault bit still follows fault_in
// - error: ready set, fail flag on errors
// - address not found for out-of-range address
// - abort on crc, failure or bad address; an out-of-range address sets only address not found
// - crc flag on dma transfer errors
// - failing sector address loaded on error
// - interrupt per pio data block
// - command cah is a dma write
// - diagnostic 90h accepted regardless of ready
// - diagnostic code into error register
// - signature loaded, drive select cleared
// - f1h takes 512 bytes password data
// - word 0 selects identifier and level
// - master revision reported as identify word 92; here only driven on master_rev_out, no identify command
// - refused password set aborts with error
// - user arms lock, master records revision
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module awd_device
  import awd_pkg::*;
#(
  parameter logic [7:0] SIG_COUNT = 8'h00,   // arbitrary signature bytes
  parameter logic [7:0] SIG_ADDR0 = 8'h00,
  parameter logic [7:0] SIG_ADDR1 = 8'h00,
  parameter logic [7:0] SIG_ADDR2 = 8'h00,
  parameter logic [7:0] SIG_DEVHEAD = 8'h00
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // link to host
  awd_link_if.dev link,
  // back-end status
  input wire logic [27:0] max_lba_in,
  input wire logic media_err_in,
  input wire logic fault_in,
  input wire logic [7:0] diag_code_in,
  input wire logic pw_refuse_in,
  // sector data to back end
  output logic sec_wr_out,
  output logic [15:0] sec_data_out,
  output logic [27:0] sec_lba_out,
  // security state
  output logic [255:0] user_pw_out,
  output logic [255:0] master_pw_out,
  output logic level_max_out,
  output logic lock_armed_out,
  output logic [15:0] master_rev_out
);
  awd_state_e state_r, state_nxt;
  logic [7:0] err_r, feat_r, cnt_r, a0_r, a1_r, a2_r, dh_r, stat_r;
  logic [27:0] lba_r;
  logic [8:0] left_r;
  logic [7:0] widx_r;
  logic ready_r, irq_r;
  logic [7:0] rdata_r;
  logic acc, blk_end, cmd_go, xfer_fail, fin_ok, fin_err;
  logic [7:0] fin_bits;
  logic [8:0] req_n;
  logic [28:0] last_lba;
  logic range_bad;

  function automatic logic [27:0] mk_lba(input logic [7:0] dh, a2, a1, a0);
    return {dh[3:0], a2, a1, a0};
  endfunction : mk_lba

  // completion status byte; fault reported from the back end
  function automatic logic [7:0] mk_status(input logic err, input logic df);
    logic [7:0] s;
    s = 8'h00;
    s[ST_READY] = 1'b1;
    s[ST_FAULT] = df;
    s[ST_FAIL] = err;
    return s;
  endfunction : mk_status

  // ----------------------------------------------------------------
  // command decode and transfer events
  // ----------------------------------------------------------------
  always_comb begin
    acc = link.dat_valid && ready_r;
    blk_end = acc && (widx_r == WORD_LAST);
    // command register taken whenever not busy, ready not required
    cmd_go = link.tf_wr && (link.tf_addr == TF_STAT_CMD) && (state_r == AWD_IDLE);
    req_n = (cnt_r == 8'h00) ? SECTORS_ZERO_COUNT : {1'b0, cnt_r};
    last_lba = {1'b0, mk_lba(dh_r, a2_r, a1_r, a0_r)} + {20'h00000, req_n} - 29'h0000001;
    range_bad = last_lba > {1'b0, max_lba_in};
    xfer_fail = 1'b0;
    fin_ok = 1'b0;
    fin_err = 1'b0;
    fin_bits = 8'h00;
    case (state_r)
      AWD_PIO, AWD_DMA: begin
        // crc error on a dma word
        if (state_r == AWD_DMA && acc && link.dat_crc_err) begin
          xfer_fail = 1'b1;
          fin_bits[ER_CRC] = 1'b1;
          fin_bits[ER_ABORT] = 1'b1;
        end else if (blk_end && media_err_in) begin
          xfer_fail = 1'b1;
          fin_bits[ER_ABORT] = 1'b1;
        end else if (blk_end && left_r == 9'h001) begin
          fin_ok = 1'b1;
        end
        fin_err = xfer_fail;
      end
      AWD_PW: begin
        if (blk_end) begin
          fin_err = pw_refuse_in;
          fin_bits[ER_ABORT] = pw_refuse_in;
          fin_ok = !pw_refuse_in;
        end
      end
      default: begin
      end
    endcase
  end

  // next state of the command sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      AWD_IDLE: begin
        if (cmd_go && dh_r[DH_LBA_MODE] && !range_bad) begin
          if (link.tf_wdata == CMD_WRITE_PIO) state_nxt = AWD_PIO;
          if (link.tf_wdata == CMD_WRITE_DMA) state_nxt = AWD_DMA;
        end
        if (cmd_go && link.tf_wdata == CMD_PW_SET) state_nxt = AWD_PW;
      end
      AWD_PIO, AWD_DMA, AWD_PW: begin
        if (fin_ok || fin_err) state_nxt = AWD_IDLE;
      end
      default: state_nxt = AWD_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer, counters and data handshake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_r <= AWD_IDLE;
      lba_r <= 28'h0000000;
      left_r <= 9'h000;
      widx_r <= 8'h00;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ready_r <= (state_nxt != AWD_IDLE);
      if (state_r == AWD_IDLE) begin
        lba_r <= mk_lba(dh_r, a2_r, a1_r, a0_r);
        left_r <= req_n;
        widx_r <= 8'h00;
      end else if (acc) begin
        widx_r <= widx_r + 8'h01;
        if (blk_end) begin
          lba_r <= lba_r + 28'h0000001;
          left_r <= left_r - 9'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // task-file registers and status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      err_r <= TF_RESET;
      feat_r <= TF_RESET;
      cnt_r <= TF_RESET;
      a0_r <= TF_RESET;
      a1_r <= TF_RESET;
      a2_r <= TF_RESET;
      dh_r <= TF_RESET;
      stat_r <= STATUS_RESET;
    end else if (state_r == AWD_IDLE && link.tf_wr) begin
      case (link.tf_addr)
        TF_ERR_FEAT: feat_r <= link.tf_wdata;
        TF_COUNT: cnt_r <= link.tf_wdata;
        TF_ADDR0: a0_r <= link.tf_wdata;
        TF_ADDR1: a1_r <= link.tf_wdata;
        TF_ADDR2: a2_r <= link.tf_wdata;
        // drive select kept as written and read back
        TF_DEVHEAD: dh_r <= link.tf_wdata;
        TF_STAT_CMD: begin
          err_r <= 8'h00;
          if (link.tf_wdata == CMD_DIAG) begin
            err_r <= diag_code_in;
            cnt_r <= SIG_COUNT;
            a0_r <= SIG_ADDR0;
            a1_r <= SIG_ADDR1;
            a2_r <= SIG_ADDR2;
            dh_r <= SIG_DEVHEAD & ~(8'h01 << DH_DRIVE_SEL);
            stat_r <= mk_status(1'b0, fault_in);
          end else if (link.tf_wdata == CMD_WRITE_PIO || link.tf_wdata == CMD_WRITE_DMA) begin
            if (!dh_r[DH_LBA_MODE]) begin
              // address not flagged as lba is refused
              err_r <= 8'h01 << ER_ABORT;
              stat_r <= mk_status(1'b1, fault_in);
            end else if (range_bad) begin
              err_r <= 8'h01 << ER_NOADDR;
              stat_r <= mk_status(1'b1, fault_in);
            end else begin
              stat_r <= 8'h01 << ST_DREQ;
              stat_r[ST_BUSY] <= (link.tf_wdata == CMD_WRITE_DMA);
              stat_r[ST_READY] <= 1'b1;
            end
          end else if (link.tf_wdata == CMD_PW_SET) begin
            stat_r <= (8'h01 << ST_DREQ) | (8'h01 << ST_READY);
          end else begin
            err_r <= 8'h01 << ER_ABORT;
            stat_r <= mk_status(1'b1, fault_in);
          end
        end
        default: begin
        end
      endcase
    end else if (fin_ok) begin
      stat_r <= mk_status(1'b0, fault_in);
    end else if (fin_err) begin
      // error completion, fail flag from error bits
      err_r <= fin_bits;
      stat_r <= mk_status(fin_bits != 8'h00, fault_in);
      if (state_r != AWD_PW) begin
        a0_r <= lba_r[7:0];
        a1_r <= lba_r[15:8];
        a2_r <= lba_r[23:16];
        dh_r[3:0] <= lba_r[27:24];
      end
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_r <= 8'h00;
    end else if (link.tf_rd) begin
      case (link.tf_addr)
        TF_ERR_FEAT: rdata_r <= err_r;
        TF_COUNT: rdata_r <= cnt_r;
        TF_ADDR0: rdata_r <= a0_r;
        TF_ADDR1: rdata_r <= a1_r;
        TF_ADDR2: rdata_r <= a2_r;
        TF_DEVHEAD: rdata_r <= dh_r;
        TF_STAT_CMD: rdata_r <= stat_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt and sector data outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      irq_r <= 1'b0;
      sec_wr_out <= 1'b0;
      sec_data_out <= 16'h0000;
      sec_lba_out <= 28'h0000000;
    end else begin
      // pulse per finished pio block and at every completion
      irq_r <= (state_r == AWD_PIO && blk_end) || fin_ok || fin_err ||
               (cmd_go && state_nxt == AWD_IDLE);
      sec_wr_out <= acc && (state_r != AWD_PW);
      sec_data_out <= link.dat_word;
      sec_lba_out <= lba_r;
    end
  end

  assign link.tf_rdata = rdata_r;
  assign link.dat_ready = ready_r;
  assign link.intrq = irq_r;

  // password block capture and stored security state
  awd_pw_capture u_pw (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .word_valid_in(acc && state_r == AWD_PW),
    .word_idx_in(widx_r),
    .word_in(link.dat_word),
    .commit_in(state_r == AWD_PW && fin_ok),
    .user_pw_out(user_pw_out),
    .master_pw_out(master_pw_out),
    .level_max_out(level_max_out),
    .lock_armed_out(lock_armed_out),
    .master_rev_out(master_rev_out)
  );
endmodule : awd_device

// *** src/awd_host.sv ***
// Purpose: host end; forwards task-file writes, mirrors device registers, pushes data words
// Assumes: software drives the command port, one strobe per cycle
// Notes: idle link cycles poll device registers 1..7 in turn into the mirror
`timescale 1ns/10ps
module awd_host
  import awd_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // software command port
  input wire logic [3:0] cmd_addr_in,
  input wire logic [15:0] cmd_wdata_in,
  input wire logic cmd_wr_in,
  input wire logic cmd_rd_in,
  output logic [15:0] cmd_rdata_out,
  // link to device
  awd_link_if.host link
);
  localparam logic [3:0] HC_PUSH = 4'h8;
  localparam logic [3:0] HC_PUSH_CRC = 4'h9;
  logic tf_wr_r, tf_rd_r, rd_q_r, dv_r, crc_r, refused_r, pw_mode_r;
  logic [2:0] addr_r, poll_r, rd_a_r;
  logic [7:0] wdata_r, irq_cnt_r;
  logic [15:0] word_r, rdata_r;
  logic [7:0] mirror_r [8];
  logic [8:0] pw_cnt_r;
  logic is_tf, is_cmd, push;

  always_comb begin
    is_tf = cmd_wr_in && cmd_addr_in[3] == 1'b0 && cmd_addr_in[2:0] != 3'h0;
    is_cmd = is_tf && cmd_addr_in[2:0] == TF_STAT_CMD;
    push = cmd_wr_in && (cmd_addr_in == HC_PUSH || cmd_addr_in == HC_PUSH_CRC);
  end

  // task-file write forwarding and register polling
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tf_wr_r <= 1'b0;
      tf_rd_r <= 1'b0;
      addr_r <= 3'h0;
      wdata_r <= 8'h00;
      poll_r <= TF_ERR_FEAT;
    end else if (is_tf && !(is_cmd && cmd_wdata_in[7:0] == CMD_WRITE_DMA && !mirror_r[TF_STAT_CMD][ST_READY])) begin
      tf_wr_r <= 1'b1;
      tf_rd_r <= 1'b0;
      addr_r <= cmd_addr_in[2:0];
      wdata_r <= cmd_wdata_in[7:0];
      // lba mode always flagged on drive/head writes
      if (cmd_addr_in[2:0] == TF_DEVHEAD) wdata_r[DH_LBA_MODE] <= 1'b1;
    end else begin
      tf_wr_r <= 1'b0;
      tf_rd_r <= 1'b1;
      addr_r <= poll_r;
      poll_r <= (poll_r == TF_STAT_CMD) ? TF_ERR_FEAT : poll_r + 3'h1;
    end
  end

  // mirror capture one cycle after each poll
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rd_q_r <= 1'b0;
      rd_a_r <= 3'h0;
      for (int i = 0; i < 8; i++) mirror_r[i] <= 8'h00;
    end else begin
      rd_q_r <= tf_rd_r;
      rd_a_r <= addr_r;
      if (rd_q_r) mirror_r[rd_a_r] <= link.tf_rdata;
    end
  end

  // data words, refusals and interrupt count
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      dv_r <= 1'b0;
      crc_r <= 1'b0;
      word_r <= 16'h0000;
      refused_r <= 1'b0;
      pw_mode_r <= 1'b0;
      pw_cnt_r <= 9'h000;
      irq_cnt_r <= 8'h00;
    end else begin
      if (link.intrq) irq_cnt_r <= irq_cnt_r + 8'h01;
      if (dv_r && link.dat_ready) dv_r <= 1'b0;
      if (is_cmd) begin
        pw_mode_r <= (cmd_wdata_in[7:0] == CMD_PW_SET);
        pw_cnt_r <= 9'h000;
        // dma write only while the device is ready
        if (cmd_wdata_in[7:0] == CMD_WRITE_DMA && !mirror_r[TF_STAT_CMD][ST_READY]) refused_r <= 1'b1;
      end
      if (push) begin
        // no more than 512 bytes in a password block
        if ((dv_r && !link.dat_ready) || (pw_mode_r && pw_cnt_r == HOST_PW_WORDS)) begin
          refused_r <= 1'b1;
        end else begin
          dv_r <= 1'b1;
          word_r <= cmd_wdata_in;
          crc_r <= (cmd_addr_in == HC_PUSH_CRC);
          pw_cnt_r <= pw_cnt_r + 9'h001;
        end
      end
      if (cmd_rd_in && cmd_addr_in == HC_PUSH) refused_r <= 1'b0;
    end
  end

  // software read data, one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_r <= 16'h0000;
    end else if (cmd_rd_in) begin
      if (cmd_addr_in == HC_PUSH) rdata_r <= {refused_r, dv_r, 6'h00, irq_cnt_r};
      else if (cmd_addr_in[3] == 1'b0) rdata_r <= {8'h00, mirror_r[cmd_addr_in[2:0]]};
      else rdata_r <= 16'h0000;
    end
  end

  assign cmd_rdata_out = rdata_r;
  assign link.tf_wr = tf_wr_r;
  assign link.tf_rd = tf_rd_r;
  assign link.tf_addr = addr_r;
  assign link.tf_wdata = wdata_r;
  assign link.dat_valid = dv_r;
  assign link.dat_word = word_r;
  assign link.dat_crc_err = crc_r;
endmodule : awd_host

// *** tb/awd_link_checker.sv ***
// Purpose: watches the link between the host and device ends
// Assumes: one clock, synchronous active-low reset
// Notes: cmd_r holds the last command taken while idle, wcnt_r the word index in a sector
`timescale 1ns/10ps
module awd_link_checker
  import awd_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // link signals
  input wire logic tf_wr,
  input wire logic tf_rd,
  input wire logic [2:0] tf_addr,
  input wire logic [7:0] tf_wdata,
  input wire logic [7:0] tf_rdata,
  input wire logic dat_valid,
  input wire logic [15:0] dat_word,
  input wire logic dat_crc_err,
  input wire logic dat_ready,
  input wire logic intrq
);
  logic [7:0] cmd_r;
  logic [7:0] wcnt_r;
  wire logic take = dat_valid && dat_ready;
  wire logic cmd_w = tf_wr && tf_addr == TF_STAT_CMD && !dat_ready;
  wire logic st_rd = tf_rd && tf_addr == TF_STAT_CMD;
  wire logic dma = cmd_r == CMD_WRITE_DMA;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // last command taken while idle
  always_ff @(posedge clk_in) begin
    if (!rstn_in) cmd_r <= 8'h00;
    else if (cmd_w) cmd_r <= tf_wdata;
  end
  // word index within the current sector, cleared outside data phases
  always_ff @(posedge clk_in) begin
    if (!rstn_in || !dat_ready) wcnt_r <= 8'h00;
    else if (take) wcnt_r <= wcnt_r + 8'h01;
  end
  // a write to the command register may start a new command, so any write cycle is left out
  irq_pulse_a: assert property (intrq && !tf_wr |=> !intrq) else $error("intrq too long");
  diag_done_a: assert property (cmd_w && tf_wdata == CMD_DIAG |=> intrq && !dat_ready) else $error("diag");
  unknown_abort_a: assert property (cmd_w && tf_wdata == 8'h00 |=> intrq && !dat_ready) else $error("unk");
  idle_status_a: assert property (st_rd && !dat_ready |=> !tf_rdata[ST_BUSY] && tf_rdata[ST_READY]
    && !tf_rdata[ST_DREQ]) else $error("idle status");
  data_status_a: assert property (st_rd && dat_ready |=> tf_rdata[ST_DREQ] && tf_rdata[ST_READY])
    else $error("data status");
  crc_stop_a: assert property (take && dat_crc_err && dma |=> !dat_ready && intrq) else $error("crc");
  sector_irq_a: assert property (take && wcnt_r == 8'hff && !dma |=> intrq) else $error("sector irq");
  mid_sector_a: assert property (take && wcnt_r != 8'hff && !(dat_crc_err && dma) |=> dat_ready && !intrq)
    else $error("mid sector");
  ready_cause_a: assert property ($rose(dat_ready) |-> $past(cmd_w)) else $error("ready cause");
endmodule : awd_link_checker

// *** tb/ata_write_diag_security_cmds_tb.sv ***
// Purpose: bench for the host and device ends joined by the link
// Assumes: 50 MHz clock, reset low for 10 cycles
// Notes: words come from a fixed seed; status expectations from ex_st
`timescale 1ns/10ps
module ata_write_diag_security_cmds_tb
  import awd_pkg::*;
;
  localparam logic [7:0] SIGC = 8'h3c;  // arbitrary signature byte
  localparam logic [7:0] SIGD = 8'hb5;  // arbitrary, bit 4 set on purpose
  logic clk_in = 1'b0, rstn_in = 1'b0, cmd_wr_in = 1'b0, cmd_rd_in = 1'b0;
  logic media_err_in = 1'b0, fault_in = 1'b0, pw_refuse_in = 1'b0;
  logic sec_wr_out, level_max_out, lock_armed_out;
  logic [3:0] cmd_addr_in = 4'h0;
  logic [7:0] diag_code_in = 8'h01, n;
  logic [15:0] cmd_wdata_in = 16'h0000, cmd_rdata_out, sec_data_out, master_rev_out;
  logic [15:0] d, pw_ctl, pw_rev, w1, w_rev;
  logic [27:0] max_lba_in = 28'h0123456, sec_lba_out, lba;
  logic [255:0] user_pw_out, master_pw_out;
  int failures = 0, checked = 0;
  integer seed = 32'h9b75;
  always #10 clk_in = ~clk_in;
  // the two ends and the link watcher
  awd_link_if link ();
  awd_host i_awd_host (.clk_in, .rstn_in, .cmd_addr_in, .cmd_wdata_in, .cmd_wr_in, .cmd_rd_in, .cmd_rdata_out, .link);
  awd_device #(.SIG_COUNT(SIGC), .SIG_DEVHEAD(SIGD)) i_awd_device (.clk_in, .rstn_in, .link, .max_lba_in,
    .media_err_in, .fault_in, .diag_code_in, .pw_refuse_in, .sec_wr_out, .sec_data_out, .sec_lba_out,
    .user_pw_out, .master_pw_out, .level_max_out, .lock_armed_out, .master_rev_out);
  awd_link_checker i_awd_link_checker (.clk_in, .rstn_in, .tf_wr(link.tf_wr), .tf_rd(link.tf_rd),
    .tf_addr(link.tf_addr), .tf_wdata(link.tf_wdata), .tf_rdata(link.tf_rdata), .dat_valid(link.dat_valid),
    .dat_word(link.dat_word), .dat_crc_err(link.dat_crc_err), .dat_ready(link.dat_ready), .intrq(link.intrq));
  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // one-cycle write strobe on the command port
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    cmd_addr_in <= a;
    cmd_wdata_in <= v;
    cmd_wr_in <= 1'b1;
    @(posedge clk_in);
    cmd_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  // read data stand in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    cmd_addr_in <= a;
    cmd_rd_in <= 1'b1;
    @(posedge clk_in);
    cmd_rd_in <= 1'b0;
    #1 v = cmd_rdata_out;
    @(posedge clk_in);
  endtask : rd
  // load count, address and drive/head, then the command; mirror settles after
  task automatic cmd(input logic [7:0] c, input logic [7:0] k, input logic [27:0] a);
    logic [7:0] v [2:7];
    v = '{k, a[7:0], a[15:8], a[23:16], {4'h1, a[27:24]}, c};
    for (int r = 2; r < 8; r++) wr(4'(r), {8'h00, v[r]});
    repeat (12) @(posedge clk_in);
  endtask : cmd
  // push words, at most one (index bad) marked crc-bad, waiting until each is taken
  task automatic push(input int cnt, input int bad);
    logic [15:0] w;
    for (int i = 0; i < cnt; i++) begin
      w = (i == 0) ? pw_ctl : (i == 17) ? pw_rev : 16'($random(seed));
      if (i == 1) w1 = w;
      wr((i == bad) ? 4'h9 : 4'h8, w);
      d = 16'h4000;
      for (int t = 0; t < 20 && d[14] !== 1'b0; t++) rd(4'h8, d);
      chk(d[15:14], 2'b00);
    end
  endtask : push
  function automatic logic [7:0] ex_st(input logic [7:0] e);
    return {2'b01, fault_in, 4'h0, e != 8'h00};
  endfunction : ex_st
  // error and status after completion
  task automatic fin(input logic [7:0] e);
    repeat (12) @(posedge clk_in);
    rd(4'h1, d);
    chk(d[7:0], e);
    rd(4'h7, d);
    chk(d[7:0], ex_st(e));
  endtask : fin
  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // main sequence
  initial begin
    pw_ctl = 16'h0000;
    pw_rev = 16'h0000;
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (12) @(posedge clk_in);
    rd(4'h7, d);
    chk(d[7:0], STATUS_RESET);
    rd(4'hf, d);
    chk(d, 16'h0000);
    $display("reset test done");
    diag_code_in <= 8'($random(seed));
    cmd(CMD_DIAG, 8'h5a, 28'h0);
    rd(4'h1, d);
    chk(d[7:0], diag_code_in);
    rd(4'h2, d);
    chk(d[7:0], SIGC);
    rd(4'h6, d);
    chk(d[7:0], SIGD & ~8'h10);
    rd(4'h7, d);
    chk(d[7:0], 8'h40);
    $display("diagnostic test done");
    lba = {8'h00, 20'($random(seed))};
    rd(4'h8, d);
    n = d[7:0];
    cmd(CMD_WRITE_PIO, 8'h01, lba);
    push(256, -1);
    fin(8'h00);
    chk(sec_lba_out, lba);
    chk(sec_data_out, cmd_wdata_in);
    rd(4'h6, d);
    chk(d[4], 1'b1);
    rd(4'h8, d);
    chk(d[7:0], n + 8'h01);
    $display("pio write test done");
    // count 0 is 256 sectors, one past the last valid address
    cmd(CMD_WRITE_PIO, 8'h00, max_lba_in - 28'd254);
    fin(8'h10);
    n = 8'($random(seed));
    cmd(CMD_WRITE_DMA, 8'h02, lba);
    push(int'(n) + 1, int'(n));
    fin(8'h84);
    rd(4'h3, d);
    chk(d[7:0], lba[7:0]);
    $display("error tests done");
    // user at maximum level, then master, then a refused request
    for (int p = 0; p < 3; p++) begin
      pw_ctl = (p == 1) ? 16'h0001 : 16'h0100;
      pw_rev = 16'($random(seed));
      if (p == 1) w_rev = pw_rev;
      pw_refuse_in <= (p == 2);
      cmd(CMD_PW_SET, 8'h00, 28'h0);
      push(256, -1);
      fin((p == 2) ? 8'h04 : 8'h00);
      chk({lock_armed_out, level_max_out}, 2'b11);
      if (p < 2) chk((p == 1) ? master_pw_out[15:0] : user_pw_out[15:0], w1);
      if (p > 0) chk(master_rev_out, w_rev);
    end
    $display("password tests done");
    fault_in <= 1'b1;
    cmd(8'h00, 8'h00, 28'h0);
    fin(8'h04);
    $display("unknown command test done");
    summarize();
  end
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk_in);
    failures++;
    summarize();
  end
endmodule : ata_write_diag_security_cmds_tb
